// ===== rtl/dsf_fifo.sv
`timescale 1ns/10ps
`default_nettype none

`include "dsf_regs.svh"

module dsf_fifo
	import dsf_pkg::*;
(
	input  wire logic                   clock,
	input  wire logic                   rstn,
	input  wire logic                   write_clock,
	input  wire logic                   write_enable_n,
	input  wire logic                   read_clock,
	input  wire logic                   read_enable_n,
	input  wire logic                   output_enable_n,
	input  wire logic                   offset_load_n,
	input  wire logic                   retransmit_strobe,
	input  wire logic                   flag_sync_select,
	input  wire logic                   fifo_reset_n,
	input  wire logic [`DSF_DATA_W-1:0] data_in,
	output logic      [`DSF_DATA_W-1:0] data_out,
	output logic                        data_out_oe,
	output logic                        empty_flag_n,
	output logic                        full_flag_n,
	output logic                        almost_empty_n,
	output logic                        almost_full_n,
	output logic                        half_level_n
);

	// ----------------------------------------
	// Pin capture
	// ----------------------------------------
	dsf_pins_t              raw;
	dsf_pins_t              pins;
	dsf_state_t             st;
	dsf_state_t             next_st;
	dsf_wr_t                wr;
	logic [`DSF_DATA_W-1:0] rdata;
	logic                   w_tick;
	logic                   r_tick;
	logic                   rt_rise;
	logic                   w_load;
	logic                   r_load;
	logic                   w_data;
	logic                   r_data;
	logic [`DSF_PTR_W-1:0]  count;
	logic                   full_now;
	logic                   empty_now;
	logic                   ae_now;
	logic                   af_now;
	logic                   hf_now;

	assign raw.wclk     = write_clock;
	assign raw.wen_n    = write_enable_n;
	assign raw.rclk     = read_clock;
	assign raw.ren_n    = read_enable_n;
	assign raw.oe_n     = output_enable_n;
	assign raw.ld_n     = offset_load_n;
	assign raw.rt       = retransmit_strobe;
	assign raw.sync_sel = flag_sync_select;
	assign raw.frst_n   = fifo_reset_n;
	assign raw.din      = data_in;

	// Clock pins are slow beside the system clock,
	// so they are sampled and edge-detected here.
	dsf_pin_sync u_sync (
		.clock (clock),
		.rstn  (rstn),
		.raw   (raw),
		.pins  (pins)
	);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	dsf_mem u_mem (
		.clock (clock),
		.wr    (wr),
		.raddr (st.rptr[`DSF_ADDR_W-1:0]),
		.rdata (rdata)
	);

	// ----------------------------------------
	// Edge enables and access decode
	// ----------------------------------------
	always_comb begin
		w_tick  = pins.wclk & ~st.wclk_q;
		r_tick  = pins.rclk & ~st.rclk_q;
		rt_rise = pins.rt & ~st.rt_q;
		// Enables ride the same two stages as the
		// clock pins, so they line up with the edge
		// offset write when load and enable low
		w_load  = w_tick & ~pins.ld_n & ~pins.wen_n;
		// offset read when load and enable low
		r_load  = r_tick & ~pins.ld_n & ~pins.ren_n;
		w_data  = w_tick & pins.ld_n & ~pins.wen_n
			& st.flags.ff_n;
		r_data  = r_tick & pins.ld_n & ~pins.ren_n
			& st.flags.ef_n;
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_st        = st;
		wr             = '0;
		count          = `DSF_PTR_RST;
		full_now       = 1'b0;
		empty_now      = 1'b1;
		ae_now         = 1'b1;
		af_now         = 1'b0;
		hf_now         = 1'b0;
		next_st.wclk_q = pins.wclk;
		next_st.rclk_q = pins.rclk;
		next_st.rt_q   = pins.rt;
		// drive only while output enable is low
		next_st.oe     = ~pins.oe_n;

		if (!pins.frst_n) begin
			next_st.wptr     = `DSF_PTR_RST;
			next_st.rptr     = `DSF_PTR_RST;
			next_st.flags.ef_n = `DSF_EF_RST;
			next_st.flags.ff_n = `DSF_FF_RST;
			next_st.flags.ae_n = `DSF_AE_RST;
			next_st.flags.af_n = `DSF_AF_RST;
			next_st.flags.hf_n = `DSF_HF_RST;
			// data low; shown only when enabled
			next_st.dout     = `DSF_DOUT_RST;
			// Offsets return too, so a reset always
			// restarts programming from known values
			// default offsets
			next_st.ae_off   = `DSF_OFF_RST;
			next_st.af_off   = `DSF_OFF_RST;
			next_st.sel      = dsf_sel_empty;
		end else begin
			// ----------------------------------------
			// Write side
			// ----------------------------------------
			if (w_load) begin
				// offsets take the low 16 bits
				unique case (st.sel)
					dsf_sel_empty: begin
						next_st.ae_off = pins.din[`DSF_OFF_W-1:0];
					end
					dsf_sel_full: begin
						next_st.af_off = pins.din[`DSF_OFF_W-1:0];
					end
				endcase
			end
			if (w_data) begin
				wr.we        = 1'b1;
				wr.waddr     = st.wptr[`DSF_ADDR_W-1:0];
				wr.wdata     = pins.din;
				next_st.wptr = st.wptr + `DSF_PTR_ONE;
			end

			// ----------------------------------------
			// Read side
			// ----------------------------------------
			if (r_load) begin
				unique case (st.sel)
					dsf_sel_empty: begin
						next_st.dout = {`DSF_OFF_PAD, st.ae_off};
					end
					dsf_sel_full: begin
						next_st.dout = {`DSF_OFF_PAD, st.af_off};
					end
				endcase
			end
			if (r_data) begin
				next_st.dout = rdata;
				next_st.rptr = st.rptr + `DSF_PTR_ONE;
			end

			// selector survives load release
			// One step per cycle, so a write and read
			// of the same offset together share it.
			if (w_load || r_load) begin
				next_st.sel = (st.sel == dsf_sel_empty)
					? dsf_sel_full : dsf_sel_empty;
			end

			// ----------------------------------------
			// Retransmit
			// ----------------------------------------
			// Rewind wins over a read in the same cycle
			// rewind to the first location
			if (rt_rise) begin
				next_st.rptr = `DSF_PTR_RST;
			end

			// ----------------------------------------
			// Flags from resulting pointers
			// ----------------------------------------
			// Next pointers, so a same-cycle write,
			// read or rewind is already counted
			count     = next_st.wptr - next_st.rptr;
			full_now  = (count == `DSF_DEPTH);
			empty_now = (count == `DSF_EMPTY);
			// almost empty at or below offset
			ae_now    = ({`DSF_CNT_PAD2, count}
				<= next_st.ae_off);
			// almost full from depth minus offset
			// Extra bit keeps a large offset from wrapping
			af_now    = ({`DSF_CNT_PAD3, count}
				+ {`DSF_OFF_PADX, next_st.af_off})
				>= `DSF_DEPTH_X;
			hf_now    = (count > `DSF_HALF);

			// Writer must only see full move at its edge
			// full only on write edges or a retransmit rise
			if (w_tick || rt_rise) begin
				next_st.flags.ff_n = ~full_now;
			end
			if (r_tick || rt_rise) begin
				next_st.flags.ef_n = ~empty_now;
			end
			if (pins.sync_sel || r_tick || rt_rise) begin
				next_st.flags.ae_n = ~ae_now;
			end
			if (pins.sync_sel || w_tick || rt_rise) begin
				next_st.flags.af_n = ~af_now;
			end
			// Valid standalone only; ignores clock edges
			// half flag on the shared pin
			next_st.flags.hf_n = ~hf_now;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st.wptr   <= `DSF_PTR_RST;
			st.rptr   <= `DSF_PTR_RST;
			st.ae_off <= `DSF_OFF_RST;
			st.af_off <= `DSF_OFF_RST;
			st.sel    <= dsf_sel_empty;
			st.dout   <= `DSF_DOUT_RST;
			st.oe     <= 1'b0;
			st.flags.ef_n <= `DSF_EF_RST;
			st.flags.ff_n <= `DSF_FF_RST;
			st.flags.ae_n <= `DSF_AE_RST;
			st.flags.af_n <= `DSF_AF_RST;
			st.flags.hf_n <= `DSF_HF_RST;
			st.wclk_q <= 1'b0;
			st.rclk_q <= 1'b0;
			st.rt_q   <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Outputs, all from flops
	// ----------------------------------------
	assign data_out       = st.dout;
	assign data_out_oe    = st.oe;
	assign empty_flag_n   = st.flags.ef_n;
	assign full_flag_n    = st.flags.ff_n;
	assign almost_empty_n = st.flags.ae_n;
	assign almost_full_n  = st.flags.af_n;
	assign half_level_n   = st.flags.hf_n;

endmodule : dsf_fifo

`default_nettype wire

// ===== rtl/dsf_mem.sv
`timescale 1ns/10ps
`default_nettype none

`include "dsf_regs.svh"

module dsf_mem
	import dsf_pkg::*;
(
	input  wire logic                   clock,
	input  wire dsf_wr_t                wr,
	input  wire logic [`DSF_ADDR_W-1:0] raddr,
	output logic      [`DSF_DATA_W-1:0] rdata
);

	// ----------------------------------------
	// Storage array, no reset
	// ----------------------------------------
	logic [`DSF_DATA_W-1:0] mem [0:`DSF_WORDS-1];

	always_ff @(posedge clock) begin
		if (wr.we) begin
			mem[wr.waddr] <= wr.wdata;
		end
	end

	// Read is combinational; the top registers it
	assign rdata = mem[raddr];

endmodule : dsf_mem

`default_nettype wire

// ===== rtl/dsf_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

module dsf_pin_sync
	import dsf_pkg::*;
(
	input  wire logic      clock,
	input  wire logic      rstn,
	input  wire dsf_pins_t raw,
	output var  dsf_pins_t pins
);

	dsf_sync_t st;
	dsf_sync_t next_st;

	// ----------------------------------------
	// Two stages; only stage two is read
	// ----------------------------------------
	always_comb begin
		next_st        = st;
		next_st.meta   = raw;
		next_st.stable = st.meta;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign pins = st.stable;

endmodule : dsf_pin_sync

`default_nettype wire

// ===== rtl/dsf_pkg.sv
`include "dsf_regs.svh"

package dsf_pkg;

	// ----------------------------------------
	// Pin bundle, sampled in the clock domain
	// ----------------------------------------
	typedef struct packed {
		logic                     wclk;
		logic                     wen_n;
		logic                     rclk;
		logic                     ren_n;
		logic                     oe_n;
		logic                     ld_n;
		logic                     rt;
		logic                     sync_sel;
		logic                     frst_n;
		logic [`DSF_DATA_W-1:0]   din;
	} dsf_pins_t;

	typedef enum logic {
		dsf_sel_empty = 1'b0,
		dsf_sel_full  = 1'b1
	} dsf_sel_t;

	typedef struct packed {
		logic                     we;
		logic [`DSF_ADDR_W-1:0]   waddr;
		logic [`DSF_DATA_W-1:0]   wdata;
	} dsf_wr_t;

	typedef struct packed {
		logic ef_n;
		logic ff_n;
		logic ae_n;
		logic af_n;
		logic hf_n;
	} dsf_flags_t;

	typedef struct packed {
		logic [`DSF_PTR_W-1:0]    wptr;
		logic [`DSF_PTR_W-1:0]    rptr;
		logic [`DSF_OFF_W-1:0]    ae_off;
		logic [`DSF_OFF_W-1:0]    af_off;
		dsf_sel_t                 sel;
		logic [`DSF_DATA_W-1:0]   dout;
		logic                     oe;
		dsf_flags_t               flags;
		logic                     wclk_q;
		logic                     rclk_q;
		logic                     rt_q;
	} dsf_state_t;

	typedef struct packed {
		dsf_pins_t meta;
		dsf_pins_t stable;
	} dsf_sync_t;

endpackage : dsf_pkg

// ===== rtl/dsf_regs.svh
`ifndef DSF_REGS_SVH
`define DSF_REGS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define DSF_DATA_W   18
`define DSF_OFF_W    16
`define DSF_ADDR_W   13
`define DSF_PTR_W    14
`define DSF_WORDS    8192

// ----------------------------------------
// Fill levels
// ----------------------------------------
`define DSF_DEPTH    14'h2000
`define DSF_DEPTH_X  17'h02000
`define DSF_HALF     14'h1000
`define DSF_EMPTY    14'h0000

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DSF_OFF_RST  16'h007f
`define DSF_PTR_RST  14'h0000
`define DSF_PTR_ONE  14'h0001
`define DSF_DOUT_RST 18'h00000
`define DSF_OFF_PAD  2'h0
`define DSF_CNT_PAD2 2'h0
`define DSF_CNT_PAD3 3'h0
`define DSF_OFF_PADX 1'h0

// ----------------------------------------
// Flag reset levels, all active low
// ----------------------------------------
`define DSF_EF_RST   1'h0
`define DSF_FF_RST   1'h1
`define DSF_AE_RST   1'h0
`define DSF_AF_RST   1'h1
`define DSF_HF_RST   1'h1

`endif

// ===== sim/dsf_fifo_checker.sv
`timescale 1ns/10ps
`default_nettype none

module dsf_fifo_checker
	import dsf_pkg::*;
(
	input wire logic        clock,
	input wire logic        rstn,
	input wire logic        write_clock,
	input wire logic        read_clock,
	input wire logic        output_enable_n,
	input wire logic        offset_load_n,
	input wire logic        retransmit_strobe,
	input wire logic        flag_sync_select,
	input wire logic        fifo_reset_n,
	input wire logic [17:0] data_out,
	input wire logic        data_out_oe,
	input wire logic        empty_flag_n,
	input wire logic        full_flag_n,
	input wire logic        almost_empty_n,
	input wire logic        almost_full_n,
	input wire logic        half_level_n
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);

	// ----
	// Sequences
	// ----
	sequence s_rst;
		!fifo_reset_n [*5];
	endsequence
	sequence s_oe_lo;
		!output_enable_n [*5];
	endsequence

	// ----
	// Properties
	// ----
	property p_rst_flags;
		s_rst |-> !empty_flag_n && full_flag_n && !almost_empty_n && almost_full_n && half_level_n;
	endproperty
	a_rst_flags: assert property (p_rst_flags) else $error("reset flags wrong");
	property p_rst_dout;
		s_rst and s_oe_lo |-> data_out == 18'h00000;
	endproperty
	a_rst_dout: assert property (p_rst_dout) else $error("reset data not low");
	property p_oe_on;
		s_oe_lo |-> data_out_oe;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("output not driven");
	property p_oe_off;
		output_enable_n [*5] |-> !data_out_oe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("output not released");
	property p_full_edge;
		$changed(full_flag_n) |-> $past(write_clock, 3) || !$past(fifo_reset_n, 2)
			|| $past(retransmit_strobe, 3);
	endproperty
	a_full_edge: assert property (p_full_edge) else $error("full moved off edge");
	property p_empty_edge;
		$changed(empty_flag_n) |-> $past(read_clock, 3) || !$past(fifo_reset_n, 2)
			|| $past(retransmit_strobe, 3);
	endproperty
	a_empty_edge: assert property (p_empty_edge) else $error("empty moved off edge");
	property p_af_sync;
		!flag_sync_select && $changed(almost_full_n) |-> $past(write_clock, 3)
			|| !$past(fifo_reset_n, 2) || $past(retransmit_strobe, 3);
	endproperty
	a_af_sync: assert property (p_af_sync) else $error("almost full off edge");
	property p_ae_sync;
		!flag_sync_select && $changed(almost_empty_n) |-> $past(read_clock, 3)
			|| !$past(fifo_reset_n, 2) || $past(retransmit_strobe, 3);
	endproperty
	a_ae_sync: assert property (p_ae_sync) else $error("almost empty off edge");
	property p_empty_hold;
		(!empty_flag_n && offset_load_n && fifo_reset_n) [*5] |-> $stable(data_out);
	endproperty
	a_empty_hold: assert property (p_empty_hold) else $error("data moved while empty");
	property p_full_levels;
		!full_flag_n [*2] |-> !half_level_n && !almost_full_n;
	endproperty
	a_full_levels: assert property (p_full_levels) else $error("full without levels");
endmodule : dsf_fifo_checker

bind dsf_fifo dsf_fifo_checker u_chk (
	.clock(clock), .rstn(rstn), .write_clock(write_clock), .read_clock(read_clock),
	.output_enable_n(output_enable_n), .offset_load_n(offset_load_n),
	.retransmit_strobe(retransmit_strobe), .flag_sync_select(flag_sync_select),
	.fifo_reset_n(fifo_reset_n), .data_out(data_out), .data_out_oe(data_out_oe),
	.empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n), .almost_empty_n(almost_empty_n),
	.almost_full_n(almost_full_n), .half_level_n(half_level_n)
);

`default_nettype wire

// ===== sim/dsf_fifo_tb.sv
`timescale 1ns/10ps
`default_nettype none

module dsf_fifo_tb
	import dsf_pkg::*;
;
	logic        clock;
	logic        rstn;
	logic        w_go;
	logic        r_go;
	logic        wclk;
	logic        rclk;
	logic        wen_n;
	logic        ren_n;
	logic        oe_n;
	logic        ld_n;
	logic        rt;
	logic        ss;
	logic        fr_n;
	logic [17:0] din;
	logic [17:0] dout;
	logic        oe;
	logic        ef;
	logic        ff;
	logic        ae;
	logic        af;
	logic        hf;
	int          err_total;
	int          compares;

	dsf_peer u_peer (.clock(clock), .rstn(rstn), .w_go(w_go), .r_go(r_go),
		.write_clock(wclk), .read_clock(rclk));
	dsf_fifo DUT (.clock(clock), .rstn(rstn), .write_clock(wclk), .write_enable_n(wen_n),
		.read_clock(rclk), .read_enable_n(ren_n), .output_enable_n(oe_n),
		.offset_load_n(ld_n), .retransmit_strobe(rt), .flag_sync_select(ss),
		.fifo_reset_n(fr_n), .data_in(din), .data_out(dout), .data_out_oe(oe),
		.empty_flag_n(ef), .full_flag_n(ff), .almost_empty_n(ae), .almost_full_n(af),
		.half_level_n(hf));

	// ----
	// Helpers
	// ----
	task chk(input string n, input logic [17:0] e, input logic [17:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task chkf(input logic [4:0] e);
		chk("flags", {13'h0000, e}, {13'h0000, ef, ff, ae, af, hf});
	endtask : chkf
	task cyc(input int n);
		repeat (n) @(negedge clock);
	endtask : cyc
	task wr(input int n, input logic [17:0] d);
		din = d;
		w_go = 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge wclk);
			@(negedge clock);
			if (i == n - 1) w_go = 1'b0;
			@(negedge wclk);
			@(negedge clock);
			din = d + 18'(i + 1);
		end
		cyc(4);
	endtask : wr
	task rd(input int n, input logic [17:0] e);
		r_go = 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge rclk);
			@(negedge clock);
			if (i == n - 1) r_go = 1'b0;
			@(negedge rclk);
			cyc(2);
			chk("dout", e + 18'(i), dout);
		end
		cyc(4);
	endtask : rd
	task frst;
		// Clocks stay still while held
		fr_n = 1'b0;
		cyc(6);
		fr_n = 1'b1;
		cyc(6);
	endtask : frst
	task complete_run;
		if (err_total == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run

	// ----
	// Scenarios
	// ----
	task t_reset;
		oe_n = 1'b1;
		cyc(6);
		chk("oe", 18'h00000, {17'h00000, oe});
		oe_n = 1'b0;
		frst;
		chk("oe", 18'h00001, {17'h00000, oe});
		chk("dout", 18'h00000, dout);
		chkf(5'h0b);
	endtask : t_reset
	task t_offsets;
		ld_n = 1'b0;
		cyc(4);
		rd(1, 18'h0007f);
		rd(1, 18'h0007f);
		wr(1, 18'h00011);
		frst;
		wr(1, 18'h30005);
		ld_n = 1'b1;
		cyc(4);
		ld_n = 1'b0;
		wr(1, 18'h00009);
		wen_n = 1'b1;
		wr(1, 18'h00077);
		wen_n = 1'b0;
		rd(1, 18'h00005);
		rd(1, 18'h00009);
		rd(1, 18'h00005);
		ld_n = 1'b1;
		cyc(4);
	endtask : t_offsets
	task t_flow;
		wr(6, 18'h00100);
		chkf(5'h0b);
		ren_n = 1'b1;
		rd(1, 18'h00005);
		ren_n = 1'b0;
		chkf(5'h1f);
		rd(2, 18'h00100);
		chkf(5'h1b);
		rt = 1'b1;
		cyc(4);
		rt = 1'b0;
		cyc(8);
		chkf(5'h1f);
		rd(3, 18'h00100);
		wr(1, 18'h00106);
		rd(4, 18'h00103);
		rd(1, 18'h00106);
		chkf(5'h0b);
	endtask : t_flow
	task t_async;
		ss = 1'b1;
		cyc(4);
		wr(6, 18'h00200);
		chkf(5'h0f);
		ss = 1'b0;
		cyc(4);
	endtask : t_async
	task t_fill;
		frst;
		wr(4096, 18'h01000);
		chkf(5'h0b);
		wr(1, 18'h02000);
		chkf(5'h0a);
		wr(3967, 18'h02001);
		chkf(5'h0a);
		wr(1, 18'h02f80);
		chkf(5'h08);
		wr(127, 18'h02f81);
		chkf(5'h00);
		wr(1, 18'h3ffff);
		ren_n = 1'b1;
		rd(1, 18'h00000);
		ren_n = 1'b0;
		rd(1, 18'h01000);
		chkf(5'h14);
	endtask : t_fill

	// ----
	// Main sequence
	// ----
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		rstn = 1'b0;
		w_go = 1'b0;
		r_go = 1'b0;
		wen_n = 1'b0;
		ren_n = 1'b0;
		oe_n = 1'b0;
		ld_n = 1'b1;
		rt = 1'b0;
		ss = 1'b0;
		fr_n = 1'b1;
		din = 18'h00000;
		err_total = 0;
		compares = 0;
		cyc(6);
		rstn = 1'b1;
		cyc(4);
		t_reset;
		t_offsets;
		t_flow;
		t_async;
		t_fill;
		complete_run;
	end
	// Fill alone takes about 66k cycles
	initial begin
		#950000;
		err_total++;
		complete_run;
	end
endmodule : dsf_fifo_tb

`default_nettype wire

// ===== sim/dsf_peer.sv
`timescale 1ns/10ps
`default_nettype none

module dsf_peer
	import dsf_pkg::*;
(
	input  wire logic clock,
	input  wire logic rstn,
	input  wire logic w_go,
	input  wire logic r_go,
	output logic      write_clock,
	output logic      read_clock
);
	logic [2:0] wc;
	logic [2:0] rc;

	// ----
	// Pin clocks, 4 high 4 low
	// ----
	// still unless asked
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wc <= 3'h0;
			rc <= 3'h0;
		end else begin
			wc <= (wc != 3'h0 || w_go) ? wc + 3'h1 : wc;
			rc <= (rc != 3'h0 || r_go) ? rc + 3'h1 : rc;
		end
	end
	// Period of 8 keeps the pin slow enough for the synchroniser
	assign write_clock = wc[2];
	assign read_clock  = rc[2];
endmodule : dsf_peer

`default_nettype wire
